// *** src/scg_cfg.svh ***
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH
`define SCG_ADDR_W         12
`define SCG_OFF_CLK_SRC    12'h000
`define SCG_OFF_DIV_LO     12'h004
`define SCG_OFF_DIV_HI     12'h008
`define SCG_OFF_MISC       12'h00C
`define SCG_OFF_STATUS     12'h010
`define SCG_RST_CLK_SRC    8'h00
`define SCG_RST_DIV        8'h00
`define SCG_RST_MISC       8'h00
`define SCG_RST_CNT        16'h0000
`define SCG_BIT_OSC_EN     7
`define SCG_BIT_RX_SRC_HI  6
`define SCG_BIT_RX_SRC_LO  5
`define SCG_BIT_TX_SRC_HI  4
`define SCG_BIT_TX_SRC_LO  3
`define SCG_BIT_BIDIR_OE   2
`define SCG_BIT_BIDIR_HI   1
`define SCG_BIT_BIDIR_LO   0
`define SCG_BIT_GEN_PCLK   1
`define SCG_BIT_GEN_EN     0
`endif

// *** src/scg_clock_gen.sv ***
`timescale 1ns/1ps
`include "scg_cfg.svh"
// Operation
// R1 - oscillator bit gates crystal amplifier enable
// R2 - oscillator replaces clock pin for consumers
// R3 - oscillator on: no sync pulse, ext sync refused
// R4 - oscillator on, async: hunt flag held 0
// R5 - two-bit field selects receive clock source
// R6 - two-bit field selects transmit clock source
// R7 - bidir pin driven only if enabled, unused
// R8 - two-bit field selects bidir pin signal
// R9 - oscillator selected while off drives high
// R10 - receiver samples on internal falling edge
// R11 - software settles selections before enabling
// R12 - 16-bit reloading counter plus divide-by-two
// R13 - reset disables generator; bit controls after
// R14 - low byte first register, high second
// R15 - rate is fin over 2(tc+2)
// R16 - select bit: 0 clock pin, 1 pclk
// R17 - software changes select only while disabled
// R18 - enable synchronised to generator clock
// R19 - clearing enable stops generator at once
// R20 - zero count reloads, toggles, pulses once
// R21 - zero held while disabled, set in reset
// R22 - reset selects clock pin for generator
// R23 - counter decrements per tick, holds disabled
module scg_clock_gen (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SCG_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   rx_tx_clock_pin,
  input  wire logic                   bidir_clock_pin_in,
  output logic                        bidir_clock_pin_out,
  output logic                        bidir_clock_pin_oe,
  input  wire logic                   sync_pin_in,
  output logic                        sync_pin_out,
  output logic                        sync_pin_oe,
  output logic                        xtal_amp_en,
  input  wire logic                   async_mode,
  input  wire logic                   sync_pulse_req,
  input  wire logic                   ext_sync_req,
  output logic                        ext_sync_granted,
  output logic                        frame_hunt_flag,
  input  wire logic                   phase_tx_clk,
  input  wire logic                   phase_rx_clk,
  output logic                        rx_clk,
  output logic                        tx_clk,
  output logic                        rx_sample,
  output logic                        gen_out,
  output logic                        gen_zero
);
  scg_pkg::scg_state_t s_q;
  scg_pkg::scg_state_t s_d;

  logic                    osc_on;
  logic                    rtx_src;
  logic                    gen_src;
  logic                    gen_tick;
  logic                    gen_run;
  logic [15:0]             tc;
  logic                    wr_en;
  logic                    rd_setup;
  logic                    addr_ok;
  logic                    rx_int;
  logic                    tx_int;
  logic                    bidir_sel_o;
  scg_pkg::scg_src_t       rx_sel;
  scg_pkg::scg_src_t       tx_sel;
  scg_pkg::scg_bidir_sel_t out_sel;

  // apb decode; the slave never waits
  assign addr_ok  = (paddr == `SCG_OFF_CLK_SRC) || (paddr == `SCG_OFF_DIV_LO)
                 || (paddr == `SCG_OFF_DIV_HI) || (paddr == `SCG_OFF_MISC)
                 || (paddr == `SCG_OFF_STATUS);
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;

  assign osc_on = s_q.clk_src[`SCG_BIT_OSC_EN];
  // amplified crystal output is seen on the pin itself
  assign rtx_src = rx_tx_clock_pin; // R2

  assign rx_sel  = scg_pkg::scg_src_t'(
                     s_q.clk_src[`SCG_BIT_RX_SRC_HI:`SCG_BIT_RX_SRC_LO]);
  assign tx_sel  = scg_pkg::scg_src_t'(
                     s_q.clk_src[`SCG_BIT_TX_SRC_HI:`SCG_BIT_TX_SRC_LO]);
  assign out_sel = scg_pkg::scg_bidir_sel_t'(
                     s_q.clk_src[`SCG_BIT_BIDIR_HI:`SCG_BIT_BIDIR_LO]);

  assign tc = {s_q.div_hi, s_q.div_lo}; // R14

  // generator input: pclk itself or rising edges of the pin
  assign gen_src  = rtx_src;
  assign gen_tick = s_q.misc[`SCG_BIT_GEN_PCLK] ? 1'b1 // R16
                  : (gen_src && !s_q.gen_src_prev);
  // enable bit low stops at once, no sync path
  assign gen_run  = s_q.misc[`SCG_BIT_GEN_EN]
                 && (s_q.gst == scg_pkg::SCG_GEN_RUN); // R19

  always_comb
  begin
    rx_int = 1'b0;
    tx_int = 1'b0;
    case (rx_sel)
      // pin path is inverted: rising pin edge is internal fall
      scg_pkg::SCG_SRC_RTX_PIN:   rx_int = !rtx_src; // R10
      scg_pkg::SCG_SRC_BIDIR_PIN: rx_int = bidir_clock_pin_in; // R5
      scg_pkg::SCG_SRC_GEN:       rx_int = s_q.gen_out;
      scg_pkg::SCG_SRC_PHASE_TX:  rx_int = phase_tx_clk;
      default:                    rx_int = 1'b0;
    endcase
    case (tx_sel)
      scg_pkg::SCG_SRC_RTX_PIN:   tx_int = rtx_src; // R6
      scg_pkg::SCG_SRC_BIDIR_PIN: tx_int = bidir_clock_pin_in;
      scg_pkg::SCG_SRC_GEN:       tx_int = s_q.gen_out;
      scg_pkg::SCG_SRC_PHASE_TX:  tx_int = phase_tx_clk;
      default:                    tx_int = 1'b0;
    endcase
  end

  always_comb
  begin
    case (out_sel)
      scg_pkg::SCG_OUT_OSC:      bidir_sel_o = osc_on ? rtx_src : 1'b1; // R9
      scg_pkg::SCG_OUT_GEN:      bidir_sel_o = s_q.gen_out; // R8
      scg_pkg::SCG_OUT_PHASE_RX: bidir_sel_o = phase_rx_clk;
      scg_pkg::SCG_OUT_TX_CLK:   bidir_sel_o = s_q.tx_clk;
      default:                   bidir_sel_o = 1'b1;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.gen_src_prev = gen_src;
    // register writes
    if (wr_en)
    begin
      case (paddr)
        `SCG_OFF_CLK_SRC: s_d.clk_src = pwdata[7:0];
        `SCG_OFF_DIV_LO:  s_d.div_lo  = pwdata[7:0];
        `SCG_OFF_DIV_HI:  s_d.div_hi  = pwdata[7:0];
        `SCG_OFF_MISC:    s_d.misc    = pwdata[7:0];
        default:          s_d.clk_src = s_q.clk_src;
      endcase
    end
    // read data captured in the setup cycle
    if (rd_setup)
    begin
      case (paddr)
        `SCG_OFF_CLK_SRC: s_d.prdata = {24'h000000, s_q.clk_src};
        `SCG_OFF_DIV_LO:  s_d.prdata = {24'h000000, s_q.div_lo};
        `SCG_OFF_DIV_HI:  s_d.prdata = {24'h000000, s_q.div_hi};
        `SCG_OFF_MISC:    s_d.prdata = {24'h000000, s_q.misc};
        `SCG_OFF_STATUS:  s_d.prdata = {s_q.cnt, 12'h000, gen_run,
                                        s_q.hunt, s_q.gen_out, s_q.zero};
        default:          s_d.prdata = 32'h00000000;
      endcase
    end
    // enable synchroniser advances on generator ticks
    if (!s_q.misc[`SCG_BIT_GEN_EN])
      s_d.gst = scg_pkg::SCG_GEN_OFF; // R19
    else if (gen_tick)
    begin
      case (s_q.gst)
        scg_pkg::SCG_GEN_OFF:   s_d.gst = scg_pkg::SCG_GEN_SYNC1; // R18
        scg_pkg::SCG_GEN_SYNC1: s_d.gst = scg_pkg::SCG_GEN_RUN;
        scg_pkg::SCG_GEN_RUN:   s_d.gst = scg_pkg::SCG_GEN_RUN;
        default:                s_d.gst = scg_pkg::SCG_GEN_OFF;
      endcase
    end
    // down-counter: tc..0 then one reload tick gives tc+2 per half
    if (gen_run && gen_tick) // R23
    begin
      if (s_q.zero)
      begin
        s_d.cnt  = tc; // R20
        s_d.zero = 1'b0;
      end
      else if (s_q.cnt == 16'h0000)
      begin
        s_d.zero    = 1'b1; // R20
        s_d.gen_out = !s_q.gen_out; // R12 R15
      end
      else
        s_d.cnt = s_q.cnt - 16'h0001;
    end
    // clock routing
    s_d.rx_clk    = rx_int;
    s_d.tx_clk    = tx_int;
    s_d.rx_sample = s_q.rx_clk && !rx_int; // R10
    s_d.bidir_oe  = s_q.clk_src[`SCG_BIT_BIDIR_OE]
                 && (rx_sel != scg_pkg::SCG_SRC_BIDIR_PIN)
                 && (tx_sel != scg_pkg::SCG_SRC_BIDIR_PIN); // R7
    s_d.bidir_out = bidir_sel_o;
    s_d.hunt      = (osc_on && async_mode) ? 1'b0 : sync_pin_in; // R4
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q              <= '0;
      s_q.clk_src      <= `SCG_RST_CLK_SRC;
      s_q.div_lo       <= `SCG_RST_DIV;
      s_q.div_hi       <= `SCG_RST_DIV;
      s_q.misc         <= `SCG_RST_MISC; // R13 R22
      s_q.cnt          <= `SCG_RST_CNT;
      s_q.gst          <= scg_pkg::SCG_GEN_OFF;
      s_q.zero         <= 1'b1; // R21
    end
    else
      s_q <= s_d;
  end

  assign prdata              = s_q.prdata;
  assign rx_clk              = s_q.rx_clk;
  assign tx_clk              = s_q.tx_clk;
  assign rx_sample           = s_q.rx_sample;
  assign gen_out             = s_q.gen_out;
  assign gen_zero            = s_q.zero;
  assign bidir_clock_pin_out = s_q.bidir_out;
  assign bidir_clock_pin_oe  = s_q.bidir_oe;
  assign frame_hunt_flag     = s_q.hunt;
  assign xtal_amp_en         = osc_on; // R1
  assign sync_pin_out        = sync_pulse_req;
  assign sync_pin_oe         = !osc_on && !async_mode && sync_pulse_req; // R3
  assign ext_sync_granted    = !osc_on && ext_sync_req; // R3

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_amp;
    ##1 xtal_amp_en == $past(s_q.clk_src[`SCG_BIT_OSC_EN]) ||
        $past(wr_en);
  endproperty
  a_amp: assert property (p_amp) else $error("amp enable wrong"); // R1

  property p_osc_sync;
    osc_on |-> !sync_pin_oe && !ext_sync_granted;
  endproperty
  a_osc_sync: assert property (p_osc_sync) else $error("sync open"); // R3

  property p_hunt;
    osc_on && async_mode ##1 osc_on |-> !frame_hunt_flag;
  endproperty
  a_hunt: assert property (p_hunt) else $error("hunt not forced low"); // R4

  property p_rx_sel;
    rx_sel == scg_pkg::SCG_SRC_PHASE_TX |=> rx_clk == $past(phase_tx_clk);
  endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("rx source wrong"); // R5

  property p_tx_sel;
    tx_sel == scg_pkg::SCG_SRC_GEN |=> tx_clk == $past(s_q.gen_out);
  endproperty
  a_tx_sel: assert property (p_tx_sel) else $error("tx source wrong"); // R6

  property p_bidir_oe;
    (rx_sel == scg_pkg::SCG_SRC_BIDIR_PIN) |=> !bidir_clock_pin_oe;
  endproperty
  a_bidir_oe: assert property (p_bidir_oe) else $error("pin driven"); // R7

  property p_osc_high;
    out_sel == scg_pkg::SCG_OUT_OSC && !osc_on |=> bidir_clock_pin_out;
  endproperty
  a_osc_high: assert property (p_osc_high) else $error("pin not high"); // R9

  property p_zero_pulse;
    gen_run && s_q.misc[`SCG_BIT_GEN_PCLK] && $rose(gen_zero)
      ##1 gen_run |-> !gen_zero;
  endproperty
  a_zero_pulse: assert property (p_zero_pulse) else $error("zero long"); // R20

  property p_toggle;
    $rose(gen_zero) |-> gen_out != $past(gen_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle at zero"); // R20

  property p_stop;
    !s_q.misc[`SCG_BIT_GEN_EN] |=> $stable(s_q.cnt) && $stable(gen_zero);
  endproperty
  a_stop: assert property (p_stop) else $error("ran while off"); // R19 R21

  property p_startup;
    $rose(s_q.misc[`SCG_BIT_GEN_EN]) |-> !gen_run ##1 !gen_run;
  endproperty
  a_startup: assert property (p_startup) else $error("no start delay"); // R18

  // amplifier only comes on through a register write
  property p_amp_rise;
    $rose(xtal_amp_en) |-> $past(wr_en);
  endproperty
  a_amp_rise: assert property (p_amp_rise) else $error("amp rise"); // R1

  property p_rx_pin;
    rx_sel == scg_pkg::SCG_SRC_RTX_PIN |=> rx_clk == !$past(rx_tx_clock_pin);
  endproperty
  a_rx_pin: assert property (p_rx_pin) else $error("rx pin path"); // R10

  property p_rx_bidir;
    rx_sel == scg_pkg::SCG_SRC_BIDIR_PIN
      |=> rx_clk == $past(bidir_clock_pin_in);
  endproperty
  a_rx_bidir: assert property (p_rx_bidir) else $error("rx bidir"); // R5

  property p_rx_gen;
    rx_sel == scg_pkg::SCG_SRC_GEN |=> rx_clk == $past(gen_out);
  endproperty
  a_rx_gen: assert property (p_rx_gen) else $error("rx gen"); // R5

  property p_tx_pin;
    tx_sel == scg_pkg::SCG_SRC_RTX_PIN |=> tx_clk == $past(rx_tx_clock_pin);
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx pin"); // R6 R2

  property p_tx_bidir;
    tx_sel == scg_pkg::SCG_SRC_BIDIR_PIN
      |=> tx_clk == $past(bidir_clock_pin_in);
  endproperty
  a_tx_bidir: assert property (p_tx_bidir) else $error("tx bidir"); // R6

  property p_tx_phase;
    tx_sel == scg_pkg::SCG_SRC_PHASE_TX |=> tx_clk == $past(phase_tx_clk);
  endproperty
  a_tx_phase: assert property (p_tx_phase) else $error("tx phase"); // R6

  property p_tx_oe;
    tx_sel == scg_pkg::SCG_SRC_BIDIR_PIN |=> !bidir_clock_pin_oe;
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("tx pin driven"); // R7

  property p_oe_on;
    s_q.clk_src[`SCG_BIT_BIDIR_OE] && rx_sel != scg_pkg::SCG_SRC_BIDIR_PIN
      && tx_sel != scg_pkg::SCG_SRC_BIDIR_PIN |=> bidir_clock_pin_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven"); // R7

  property p_out_gen;
    out_sel == scg_pkg::SCG_OUT_GEN |=> bidir_clock_pin_out == $past(gen_out);
  endproperty
  a_out_gen: assert property (p_out_gen) else $error("pin gen"); // R8

  property p_out_phase;
    out_sel == scg_pkg::SCG_OUT_PHASE_RX
      |=> bidir_clock_pin_out == $past(phase_rx_clk);
  endproperty
  a_out_phase: assert property (p_out_phase) else $error("pin phase"); // R8

  property p_out_tx;
    out_sel == scg_pkg::SCG_OUT_TX_CLK
      |=> bidir_clock_pin_out == $past(tx_clk);
  endproperty
  a_out_tx: assert property (p_out_tx) else $error("pin tx clock"); // R8

  property p_sample;
    rx_sample |-> !rx_clk && $past(rx_clk);
  endproperty
  a_sample: assert property (p_sample) else $error("bad sample"); // R10

  property p_reload;
    gen_run && gen_tick && gen_zero |=> s_q.cnt == $past(tc) && !gen_zero;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload"); // R20 R14

  property p_dec;
    gen_run && gen_tick && !gen_zero && s_q.cnt != 16'h0000
      |=> s_q.cnt == $past(s_q.cnt) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement"); // R23

  property p_zero_set;
    gen_run && gen_tick && !gen_zero && s_q.cnt == 16'h0000 |=> gen_zero;
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero missed"); // R20

  property p_no_tick;
    !gen_tick |=> $stable(s_q.cnt);
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("count moved"); // R23

  property p_hunt_follow;
    !osc_on |=> frame_hunt_flag == $past(sync_pin_in);
  endproperty
  a_hunt_follow: assert property (p_hunt_follow) else $error("hunt"); // R4
endmodule : scg_clock_gen

// *** src/scg_pkg.sv ***
package scg_pkg;
  typedef enum logic [1:0] {
    SCG_SRC_RTX_PIN,
    SCG_SRC_BIDIR_PIN,
    SCG_SRC_GEN,
    SCG_SRC_PHASE_TX
  } scg_src_t;

  typedef enum logic [1:0] {
    SCG_OUT_OSC,
    SCG_OUT_GEN,
    SCG_OUT_PHASE_RX,
    SCG_OUT_TX_CLK
  } scg_bidir_sel_t;

  typedef enum logic [1:0] {
    SCG_GEN_OFF,
    SCG_GEN_SYNC1,
    SCG_GEN_RUN
  } scg_gen_state_t;

  typedef struct packed {
    logic [7:0]     clk_src;
    logic [7:0]     div_lo;
    logic [7:0]     div_hi;
    logic [7:0]     misc;
    logic [15:0]    cnt;
    scg_gen_state_t gst;
    logic           gen_out;
    logic           zero;
    logic           gen_src_prev;
    logic           rx_clk;
    logic           tx_clk;
    logic           rx_sample;
    logic           bidir_out;
    logic           bidir_oe;
    logic           hunt;
    logic [31:0]    prdata;
  } scg_state_t;
endpackage : scg_pkg

// *** verification/scg_far_side.sv ***
`timescale 1ns/1ps
// external clock source and line equipment on the far side of the pins
module scg_far_side (
  input  wire logic pclk,
  input  wire logic run,
  input  wire logic rt_lvl,
  input  wire logic bd_lvl,
  input  wire logic bd_out,
  input  wire logic bd_oe,
  output logic      rt_pin,
  output logic      bd_pin
);
  logic [1:0] ph = 2'h0;
  // free clock of four pclk periods while running, else a static level
  always @(posedge pclk)
    ph <= run ? ph + 2'h1 : 2'h0;
  assign rt_pin = run ? ph[1] : rt_lvl;
  // resolved wire level of the two-way pin
  assign bd_pin = bd_oe ? bd_out : bd_lvl;
endmodule : scg_far_side

// *** verification/serial_clock_select_and_rate_gen_test.sv ***
`timescale 1ns/1ps
module serial_clock_select_and_rate_gen_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, run = 1'b0, async_mode = 1'b0, ext_req = 1'b0;
  logic        rt_lvl = 1'b0, bd_lvl = 1'b0, ph_tx = 1'b0, ph_rx = 1'b0;
  logic        sync_in = 1'b0, sync_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, rd2;
  logic        pready, pslverr, er, rt_pin, bd_pin, bd_out, bd_oe, g0, z0;
  logic        granted, xtal, sync_oe, hunt, rx_clk, tx_clk, rx_sample;
  logic        gen_out, gen_zero;
  int          err_count = 0, n_checks = 0, seed = 82653, cyc = 0;
  int          i, k, rs, ts, sel, tc, n, smp;

  scg_clock_gen i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_tx_clock_pin(rt_pin),
    .bidir_clock_pin_in(bd_pin), .bidir_clock_pin_out(bd_out),
    .bidir_clock_pin_oe(bd_oe), .sync_pin_in(sync_in), .sync_pin_out(),
    .sync_pin_oe(sync_oe), .xtal_amp_en(xtal), .async_mode(async_mode),
    .sync_pulse_req(sync_req), .ext_sync_req(ext_req),
    .ext_sync_granted(granted), .frame_hunt_flag(hunt),
    .phase_tx_clk(ph_tx), .phase_rx_clk(ph_rx), .rx_clk(rx_clk),
    .tx_clk(tx_clk), .rx_sample(rx_sample), .gen_out(gen_out),
    .gen_zero(gen_zero)
  );

  scg_far_side i_far (
    .pclk(pclk), .run(run), .rt_lvl(rt_lvl), .bd_lvl(bd_lvl),
    .bd_out(bd_out), .bd_oe(bd_oe), .rt_pin(rt_pin), .bd_pin(bd_pin)
  );

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      give_verdict;
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 50)
    begin
      t++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle(int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // waits for a generator toggle, counting cycles and receiver samples
  task automatic tog;
    n = 0;
    smp = 0;
    g0 = gen_out;
    do
    begin
      @(negedge pclk);
      n++;
      smp += int'(rx_sample === 1'b1);
    end while (gen_out === g0 && n < 5000);
  endtask : tog

  function automatic int src(int s, int inv);
    case (s)
      0: return inv ? !rt_lvl : rt_lvl;
      1: return bd_lvl;
      2: return 0;
      default: return ph_tx;
    endcase
  endfunction : src

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    chk("gen_zero", 1, gen_zero);
    chk("gen_out", 0, gen_out);
    chk("bidir_oe", 0, bd_oe);
    apb(1'b0, 12'h010, 0);
    chk("status", 32'h1, rd & 32'hB);
    apb(1'b0, 12'h00C, 0);
    chk("misc", 0, rd);
    apb(1'b0, 12'h014, 0);
    chk("unmapped", 1, er);
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, 12'h000, 32'(i << 7));
      ext_req <= 1'b1;
      sync_req <= 1'b1;
      sync_in <= 1'b1;
      async_mode <= 1'b0;
      settle(3);
      chk("xtal", i, xtal);
      chk("granted", !i, granted);
      chk("sync_oe", !i, sync_oe);
      @(posedge pclk);
      async_mode <= 1'b1;
      settle(3);
      chk("hunt", !i, hunt);
    end
    for (i = 0; i < 16; i++)
    begin
      rs = $random(seed) & 3;
      ts = $random(seed) & 3;
      sel = $random(seed) & 3;
      @(posedge pclk);
      {rt_lvl, bd_lvl, ph_tx, ph_rx} <= 4'($random(seed));
      apb(1'b1, 12'h000, 32'((rs << 5) | (ts << 3) | 4 | sel));
      settle(3);
      chk("rx_clk", src(rs, 1), rx_clk);
      chk("tx_clk", src(ts, 0), tx_clk);
      k = int'(rs != 1 && ts != 1);
      chk("bidir_oe", k, bd_oe);
      if (k == 1)
        chk("bidir_out", sel == 0 ? 1 : sel == 1 ? 0 : sel == 2 ? ph_rx
            : src(ts, 0), bd_out);
    end
    for (k = 1; k >= 0; k--)
    begin
      tc = $random(seed) & 16'h01FF;
      apb(1'b1, 12'h000, 0);
      apb(1'b1, 12'h004, 32'(tc & 8'hFF));
      apb(1'b1, 12'h008, 32'(tc >> 8));
      apb(1'b1, 12'h00C, 32'(k << 1));
      @(posedge pclk);
      run <= !k;
      apb(1'b1, 12'h00C, 32'((k << 1) | 1));
      tog;
      tog;
      chk("half_period", (tc + 2) * (k ? 1 : 4), n);
      chk("rx_samples", k ? 0 : tc + 2, smp);
      if (k == 1)
      begin
        chk("zero_on", 1, gen_zero);
        @(negedge pclk);
        chk("zero_off", 0, gen_zero);
      end
      apb(1'b1, 12'h00C, 32'(k << 1));
      settle(1);
      g0 = gen_out;
      z0 = gen_zero;
      apb(1'b0, 12'h010, 0);
      rd2 = rd;
      settle(40);
      chk("out_held", g0, gen_out);
      chk("zero_held", z0, gen_zero);
      apb(1'b0, 12'h010, 0);
      chk("count_held", rd2 & 32'hFFFF0003, rd & 32'hFFFF0003);
      chk("running", 0, rd & 32'h8);
      @(posedge pclk);
      run <= 1'b0;
    end
    give_verdict;
  end
endmodule : serial_clock_select_and_rate_gen_test
